// File: cac_defs.vh
`ifndef CAC_DEFS_VH
`define CAC_DEFS_VH
// Register byte addresses on APB
`define CAC_ADDR_CTRL 8'h00
`define CAC_ADDR_MODE 8'h04
`define CAC_ADDR_CNTL 8'h08
`define CAC_ADDR_CNTH 8'h0C
`define CAC_ADDR_MOD0 8'h10
`define CAC_MOD_STRIDE 8'h10
`define CAC_OFF_MMODE 4'h0
`define CAC_OFF_VLOW 4'h4
`define CAC_OFF_VHIGH 4'h8
// array_mode_reg fields
`define CAC_MD_OVF_IE 0
`define CAC_MD_TB_LSB 1
`define CAC_MD_TB_MSB 3
`define CAC_MD_IDLE_STOP 7
// array_control_reg fields
`define CAC_CN_RUN 6
`define CAC_CN_OVF 7
// module_mode_reg fields
`define CAC_MM_FLAG_IE 0
`define CAC_MM_PWM 1
`define CAC_MM_TOG 2
`define CAC_MM_MAT 3
`define CAC_MM_CAPN 4
`define CAC_MM_CAPP 5
`define CAC_MM_ECOM 6
`define CAC_MM_WIDE 7
// Timebase encodings
`define CAC_TB_DIV12 3'h0
`define CAC_TB_DIV4 3'h1
`define CAC_TB_T0OVF 3'h2
`define CAC_TB_EVENT 3'h3
`define CAC_TB_SYSCLK 3'h4
`define CAC_TB_EXTOSC 3'h5
// Divider terminal counts
`define CAC_DIV12_LAST 4'hB
`define CAC_DIV4_LAST 2'h3
`define CAC_OSC_DIV_LAST 3'h7
`endif

// File: cac_core.v
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "cac_defs.vh"
module cac_core #(
   parameter NMOD = 5
) (
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Timebase sources and processor state
   input wire timer0_ovf,
   input wire ext_osc_clk,
   input wire external_count_input,
   input wire cpu_idle,
   // Module pins, routing and interrupt
   input wire route_enable,
   input wire [NMOD-1:0] module_pin_in,
   output reg [NMOD-1:0] module_pin_out,
   output reg [NMOD-1:0] module_pin_oe,
   output reg irq
);
   reg [7:0] array_control_ff;
   reg [7:0] array_mode_ff;
   reg [15:0] count_ff;
   reg [7:0] snap_high_ff;
   reg [3:0] div_ff;
   reg [NMOD-1:0] pin_s1_ff, pin_s2_ff, pin_s3_ff;
   reg [2:0] evt_ff, osc_ff;
   reg [2:0] osc_div_ff;
   reg [1:0] evt_gap_ff;
   reg [7:0] mmode_ff [0:NMOD-1];
   reg [15:0] mval_ff [0:NMOD-1];
   reg [NMOD-1:0] flag_ff;
   reg [NMOD-1:0] pout_ff;
   reg tick;
   reg [31:0] nxt_prdata;
   reg bad_addr;
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire rd = psel & ~penable & ~pwrite; // Read setup, same edge that latches prdata
   wire [2:0] tsel = array_mode_ff[`CAC_MD_TB_MSB:`CAC_MD_TB_LSB];
   wire evt_fall = evt_ff[2] & ~evt_ff[1];
   wire osc_rise = ~osc_ff[2] & osc_ff[1];
   wire running = array_control_ff[`CAC_CN_RUN] & ~(array_mode_ff[`CAC_MD_IDLE_STOP] & cpu_idle);
   wire step = running & tick;
   wire wrap = step & (count_ff == 16'hFFFF);
   wire [15:0] cnt_inc = count_ff + 16'h0001;
   wire [NMOD-1:0] cap_hit;
   wire [NMOD-1:0] cmp_hit;
   wire [NMOD-1:0] low_wrap_hit;
   wire [NMOD-1:0] irq_terms;
   wire [3:0] msel = paddr[7:4] - 4'h1;
   wire mod_space = (paddr >= `CAC_ADDR_MOD0) && (msel < NMOD);

   // Timebase tick selection
   // timebase source select
   always @*
   begin
      case (tsel)
         `CAC_TB_DIV12: tick = (div_ff == `CAC_DIV12_LAST);
         `CAC_TB_DIV4: tick = (div_ff[1:0] == `CAC_DIV4_LAST);
         `CAC_TB_T0OVF: tick = timer0_ovf;
         `CAC_TB_EVENT: tick = evt_fall & (evt_gap_ff == 2'h0);
         `CAC_TB_SYSCLK: tick = 1'b1;
         `CAC_TB_EXTOSC: tick = osc_rise & (osc_div_ff == `CAC_OSC_DIV_LAST);
         default: tick = 1'b0;
      endcase
   end

   // Prescalers and input synchronisers
   // two-stage sync then edge
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_ff <= 4'h0;
         evt_ff <= 3'h0; // Low, so a high idle pin gives no false fall
         osc_ff <= 3'h0;
         osc_div_ff <= 3'h0;
         evt_gap_ff <= 2'h0;
         pin_s1_ff <= {NMOD{1'b0}};
         pin_s2_ff <= {NMOD{1'b0}};
         pin_s3_ff <= {NMOD{1'b0}};
      end
      else
      begin
         div_ff <= (div_ff == `CAC_DIV12_LAST) ? 4'h0 : div_ff + 4'h1;
         evt_ff <= {evt_ff[1:0], external_count_input};
         osc_ff <= {osc_ff[1:0], ext_osc_clk};
         if (osc_rise)
            osc_div_ff <= osc_div_ff + 3'h1;
         // Event counting limited to sysclk/4
         if (evt_fall && evt_gap_ff == 2'h0)
            evt_gap_ff <= `CAC_DIV4_LAST;
         else if (evt_gap_ff != 2'h0)
            evt_gap_ff <= evt_gap_ff - 2'h1;
         pin_s1_ff <= module_pin_in;
         pin_s2_ff <= pin_s1_ff;
         pin_s3_ff <= pin_s2_ff;
      end
   end

   // Counter, snapshot and array control
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_ff <= 16'h0000;
         snap_high_ff <= 8'h00;
         array_control_ff <= 8'h00;
         array_mode_ff <= 8'h00;
      end
      else
      begin
         if (wr && paddr == `CAC_ADDR_CNTL)
            count_ff <= {count_ff[15:8], pwdata[7:0]};
         else if (wr && paddr == `CAC_ADDR_CNTH)
            count_ff <= {pwdata[7:0], count_ff[7:0]};
         else if (step)
            count_ff <= cnt_inc;
         if (rd && paddr == `CAC_ADDR_CNTL)
            snap_high_ff <= count_ff[15:8];
         if (wr && paddr == `CAC_ADDR_MODE)
            array_mode_ff <= pwdata[7:0];
         if (wr && paddr == `CAC_ADDR_CTRL)
            array_control_ff[`CAC_CN_RUN] <= pwdata[`CAC_CN_RUN];
         if (wrap)
            array_control_ff[`CAC_CN_OVF] <= 1'b1;
         else if (wr && paddr == `CAC_ADDR_CTRL)
            array_control_ff[`CAC_CN_OVF] <= pwdata[`CAC_CN_OVF];
      end
   end

   // Per-module capture, compare and PWM
   // five independent modules
   genvar g;
   generate
      for (g = 0; g < NMOD; g = g + 1)
      begin : g_mod
         wire [7:0] mm = mmode_ff[g];
         wire is_cap = ~mm[`CAC_MM_MAT] & ~mm[`CAC_MM_TOG] & ~mm[`CAC_MM_PWM];
         wire rise = pin_s2_ff[g] & ~pin_s3_ff[g];
         wire fall = ~pin_s2_ff[g] & pin_s3_ff[g];
         wire ecom = mm[`CAC_MM_ECOM];
         wire capsz = ~mm[`CAC_MM_CAPP] & ~mm[`CAC_MM_CAPN];
         wire pwm = ecom & capsz & mm[`CAC_MM_PWM] & ~mm[`CAC_MM_TOG];
         wire freq = ecom & capsz & mm[`CAC_MM_PWM] & mm[`CAC_MM_TOG];
         wire wide = mm[`CAC_MM_WIDE];
         wire hit_me = wr & mod_space & (msel == g);
         assign cap_hit[g] = is_cap & ((mm[`CAC_MM_CAPP] & rise) | (mm[`CAC_MM_CAPN] & fall));
         assign cmp_hit[g] = step & ecom & capsz & ~mm[`CAC_MM_PWM] & mm[`CAC_MM_MAT] & (cnt_inc == mval_ff[g]);
         assign low_wrap_hit[g] = step & (cnt_inc[7:0] == 8'h00);
         assign irq_terms[g] = flag_ff[g] & mm[`CAC_MM_FLAG_IE];
         always @(posedge mclk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               mmode_ff[g] <= 8'h00;
               mval_ff[g] <= 16'h0000;
               flag_ff[g] <= 1'b0;
               pout_ff[g] <= 1'b0;
            end
            else
            begin
               if (hit_me && paddr[3:0] == `CAC_OFF_MMODE)
                  mmode_ff[g] <= pwdata[7:0];
               else if (hit_me && paddr[3:0] == `CAC_OFF_VLOW)
                  mmode_ff[g][`CAC_MM_ECOM] <= 1'b0;
               else if (hit_me && paddr[3:0] == `CAC_OFF_VHIGH)
                  mmode_ff[g][`CAC_MM_ECOM] <= 1'b1;
               if (cap_hit[g])
                  mval_ff[g] <= count_ff;
               else if (hit_me && paddr[3:0] == `CAC_OFF_VLOW)
                  mval_ff[g] <= {mval_ff[g][15:8], pwdata[7:0]};
               else if (hit_me && paddr[3:0] == `CAC_OFF_VHIGH)
                  mval_ff[g] <= {pwdata[7:0], mval_ff[g][7:0]};
               else if (freq && step && cnt_inc[7:0] == mval_ff[g][7:0])
                  mval_ff[g] <= {mval_ff[g][15:8], mval_ff[g][7:0] + mval_ff[g][15:8]};
               else if (pwm && !wide && low_wrap_hit[g])
                  mval_ff[g] <= {mval_ff[g][15:8], mval_ff[g][15:8]};
               if (cap_hit[g] || cmp_hit[g])
                  flag_ff[g] <= 1'b1;
               else if (wr && paddr == `CAC_ADDR_CTRL)
                  flag_ff[g] <= pwdata[g];
               if (cmp_hit[g] && mm[`CAC_MM_TOG])
                  pout_ff[g] <= ~pout_ff[g];
               else if (freq && step && cnt_inc[7:0] == mval_ff[g][7:0])
                  pout_ff[g] <= ~pout_ff[g];
               else if (pwm && !wide && step && cnt_inc[7:0] == mval_ff[g][7:0])
                  pout_ff[g] <= 1'b1;
               else if (pwm && wide && step && cnt_inc == mval_ff[g])
                  pout_ff[g] <= 1'b1;
               else if (pwm && ((!wide && low_wrap_hit[g]) || (wide && wrap)))
                  pout_ff[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // APB read mux
   // pin level readable
   always @*
   begin
      nxt_prdata = 32'h00000000;
      bad_addr = 1'b0;
      case (paddr)
         `CAC_ADDR_CTRL: nxt_prdata[7:0] = {array_control_ff[7:6], 1'b0, flag_ff};
         `CAC_ADDR_MODE: nxt_prdata[7:0] = array_mode_ff;
         `CAC_ADDR_CNTL: nxt_prdata[7:0] = count_ff[7:0];
         `CAC_ADDR_CNTH: nxt_prdata[7:0] = snap_high_ff;
         default:
         begin
            if (mod_space && paddr[3:0] == `CAC_OFF_MMODE)
               nxt_prdata[7:0] = mmode_ff[msel[2:0]];
            else if (mod_space && paddr[3:0] == `CAC_OFF_VLOW)
               nxt_prdata[7:0] = mval_ff[msel[2:0]][7:0];
            else if (mod_space && paddr[3:0] == `CAC_OFF_VHIGH)
            begin
               nxt_prdata[7:0] = mval_ff[msel[2:0]][15:8];
               nxt_prdata[8 +: NMOD] = pin_s2_ff;
            end
            else
               bad_addr = 1'b1;
         end
      endcase
   end

   // Registered outputs
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         module_pin_out <= {NMOD{1'b0}};
         module_pin_oe <= {NMOD{1'b0}};
         irq <= 1'b0;
      end
      else
      begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & bad_addr;
         prdata <= (psel & ~penable & ~pwrite) ? nxt_prdata : 32'h00000000;
         module_pin_out <= pout_ff;
         module_pin_oe <= {NMOD{route_enable}} & pin_drive_mask(1'b0);
         irq <= (array_control_ff[`CAC_CN_OVF] & array_mode_ff[`CAC_MD_OVF_IE]) | (|irq_terms);
      end
   end

   // Pins driven only in compare-output modes
   function [NMOD-1:0] pin_drive_mask;
      input dummy;
      integer i;
      begin
         for (i = 0; i < NMOD; i = i + 1)
            pin_drive_mask[i] = mmode_ff[i][`CAC_MM_ECOM] & (mmode_ff[i][`CAC_MM_TOG] | mmode_ff[i][`CAC_MM_PWM]);
      end
   endfunction
endmodule // cac_core

// File: cac_core_asserts.sv
`timescale 1ns/1ps
module cac_core_asserts #(
   parameter NMOD = 5
) (
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // APB
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // Sources and pins
   input wire timer0_ovf,
   input wire ext_osc_clk,
   input wire external_count_input,
   input wire cpu_idle,
   input wire route_enable,
   input wire [NMOD-1:0] module_pin_in,
   input wire [NMOD-1:0] module_pin_out,
   input wire [NMOD-1:0] module_pin_oe,
   input wire irq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Write access phase
   wire wr_acc = psel & penable & pwrite;
   // Pins steady long enough to pass the synchroniser
   sequence s_pins_quiet;
      $stable(module_pin_in) [*4];
   endsequence
   // Read of any module's value high byte
   sequence s_pin_read;
      pready && !pwrite && paddr[3:0] == 4'h8 && paddr[7:4] >= 4'h1 && paddr[7:4] <= NMOD;
   endsequence
   property p_answer; psel && !penable |=> pready; endproperty
   a_answer: assert property (p_answer) else $error("no answer after setup");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
   property p_access; pready |-> psel && penable; endproperty
   a_access: assert property (p_access) else $error("ready outside access phase");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_unmapped; pready && paddr == 8'hFC |-> pslverr && (pwrite || prdata == 32'h0); endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   property p_route; !route_enable |=> module_pin_oe == {NMOD{1'b0}}; endproperty
   a_route: assert property (p_route) else $error("pin driven while unrouted");
   property p_hold; $fell(irq) |-> $past(wr_acc) || $past(wr_acc, 2); endproperty
   a_hold: assert property (p_hold) else $error("request dropped without write");
   property p_pins; s_pins_quiet ##0 s_pin_read |-> prdata[8 +: NMOD] == module_pin_in; endproperty
   a_pins: assert property (p_pins) else $error("pin level not readable");
endmodule // cac_core_asserts

// File: cac_pin_drv.sv
`timescale 1ns/1ps
module cac_pin_drv #(
   parameter NMOD = 5,
   parameter HOLD = 3
) (
   // Clock and reset
   input wire mclk,
   input wire rst_n,
   // Requested and driven levels
   input wire [NMOD-1:0] want,
   output reg [NMOD-1:0] pins_ff
);
   integer age_ff;
   // level hold
   // Follow request, holding each level at least HOLD+1 cycles
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pins_ff <= {NMOD{1'b0}};
         age_ff <= 0;
      end
      else if (want != pins_ff && age_ff >= HOLD)
      begin
         pins_ff <= want;
         age_ff <= 0;
      end
      else
         age_ff <= age_ff + 1;
   end
endmodule // cac_pin_drv

// File: tb_top.sv
`timescale 1ns/1ps
`include "cac_defs.vh"
module tb_top;
   localparam NMOD = 5;
   reg mclk = 1'b0;
   reg rst_n = 1'b0;
   reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er = 1'b0;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h0, rd = 32'h0, v0 = 32'h0;
   reg timer0_ovf = 1'b0, ext_osc_clk = 1'b0, external_count_input = 1'b1, cpu_idle = 1'b0, route_enable = 1'b0;
   reg [NMOD-1:0] want = {NMOD{1'b0}};
   wire [31:0] prdata;
   wire pready, pslverr, irq;
   wire [NMOD-1:0] module_pin_in, module_pin_out, module_pin_oe;
   integer err_count = 0, checks_done = 0, cyc = 0, c0, n, m, k;

   cac_core #(.NMOD(NMOD)) u_cac_core (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer0_ovf(timer0_ovf), .ext_osc_clk(ext_osc_clk), .external_count_input(external_count_input),
      .cpu_idle(cpu_idle), .route_enable(route_enable), .module_pin_in(module_pin_in),
      .module_pin_out(module_pin_out), .module_pin_oe(module_pin_oe), .irq(irq));
   cac_pin_drv #(.NMOD(NMOD)) u_cac_pin_drv (.mclk(mclk), .rst_n(rst_n), .want(want), .pins_ff(module_pin_in));

   always #25 mclk = ~mclk;
   // Tick sources and hang limit
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      timer0_ovf <= (cyc % 3 == 0);
      ext_osc_clk <= cyc[1];
      external_count_input <= cyc[2];
      if (cyc == 40000)
      begin
         err_count = err_count + 1;
         conclude;
      end
   end
   // Counts expected from a timebase over a window
   function integer ticks(input [2:0] tb, input integer cycles);
      case (tb)
         3'h0: ticks = cycles / 12;
         3'h1: ticks = cycles / 4;
         3'h2: ticks = cycles / 3;
         3'h3: ticks = cycles / 8;
         3'h4: ticks = cycles;
         3'h5: ticks = cycles / 32;
         default: ticks = 0;
      endcase
   endfunction
   // Compare and count
   task chk(input string what, input [31:0] seen, input [31:0] exp);
   begin
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
         err_count = err_count + 1;
         $display("ERROR %0s expected %h seen %h", what, exp, seen);
      end
   end
   endtask
   // One APB transfer, then an idle edge
   task apb(input w, input [7:0] a, input [31:0] d);
      integer t;
   begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      t = 0;
      do
      begin
         @(posedge mclk);
         t = t + 1;
      end while (pready !== 1'b1 && t < 50);
      rd = prdata;
      er = pslverr;
      if (t >= 50)
         err_count = err_count + 1;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   end
   endtask
   // Verdict
   task conclude;
   begin
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   end
   endtask
   // Test sequence
   initial
   begin
      void'($urandom(32'h83d3));
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      apb(1'b0, 8'hFC, 32'h0);
      chk("unmap", {rd[31:1], er}, 32'h1);
      $display("unmapped done");
      for (k = 0; k < 7; k = k + 1)
      begin
         apb(1'b1, `CAC_ADDR_MODE, k << 1);
         apb(1'b1, `CAC_ADDR_CTRL, 32'h40);
         apb(1'b0, `CAC_ADDR_CNTL, 32'h0);
         v0 = rd;
         c0 = cyc;
         repeat (200 + $urandom % 50) @(posedge mclk);
         apb(1'b0, `CAC_ADDR_CNTL, 32'h0);
         m = ((rd - v0) & 255) - ticks(k[2:0], cyc - c0);
         chk("rate", m >= -1 && m <= 1, 1);
      end
      $display("timebase done");
      apb(1'b1, `CAC_ADDR_CTRL, 32'h0);
      apb(1'b1, `CAC_ADDR_MODE, 32'h8);
      apb(1'b1, `CAC_ADDR_CNTL, 32'hF0);
      apb(1'b1, `CAC_ADDR_CNTH, 32'hFF);
      apb(1'b1, `CAC_ADDR_CTRL, 32'h40);
      repeat (40) @(posedge mclk);
      apb(1'b0, `CAC_ADDR_CTRL, 32'h0);
      chk("ovf", rd[7], 1);
      chk("irq_masked", irq, 0);
      apb(1'b0, `CAC_ADDR_CNTL, 32'h0);
      repeat (300) @(posedge mclk);
      apb(1'b0, `CAC_ADDR_CNTH, 32'h0);
      chk("snap", rd[7:0], 0);
      apb(1'b1, `CAC_ADDR_MODE, 32'h9);
      repeat (100) @(posedge mclk);
      chk("irq_held", irq, 1);
      apb(1'b1, `CAC_ADDR_CTRL, 32'h0);
      repeat (3) @(posedge mclk);
      chk("irq_clr", irq, 0);
      $display("overflow done");
      for (k = 0; k < 2; k = k + 1)
      begin
         apb(1'b1, `CAC_ADDR_MODE, 32'h8 | (k << 7));
         apb(1'b1, `CAC_ADDR_CTRL, 32'h40);
         cpu_idle <= 1'b1;
         apb(1'b0, `CAC_ADDR_CNTL, 32'h0);
         v0 = rd;
         repeat (20) @(posedge mclk);
         apb(1'b0, `CAC_ADDR_CNTL, 32'h0);
         cpu_idle <= 1'b0;
         chk("idle", rd[7:0] == v0[7:0], k);
      end
      $display("idle done");
      for (k = 0; k < 3; k = k + 1)
      begin
         n = $urandom % NMOD;
         apb(1'b1, 8'(16 * n + 16), ((k + 1) << 4) | 1);
         for (m = 0; m < 2; m = m + 1)
         begin
            apb(1'b1, `CAC_ADDR_CTRL, 32'h40);
            apb(1'b0, `CAC_ADDR_CNTL, 32'h0);
            v0 = rd;
            want[n] <= ~want[n];
            repeat (8) @(posedge mclk);
            apb(1'b0, `CAC_ADDR_CTRL, 32'h0);
            chk("flag", rd[n], (m == 0) ? (k != 0) : (k != 1));
            chk("irq_cap", irq, (m == 0) ? (k != 0) : (k != 1));
            apb(1'b0, 8'(16 * n + 20), 32'h0);
            if ((m == 0) ? (k != 0) : (k != 1))
               chk("capval", ((rd - v0) & 255) < 20, 1);
            apb(1'b0, 8'(16 * n + 24), 32'h0);
            chk("pinlvl", rd[8 + n], want[n]);
         end
      end
      $display("capture done");
      apb(1'b1, `CAC_ADDR_MOD0, 32'h4C);
      route_enable <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("oe_on", module_pin_oe, 1);
      route_enable <= 1'b0;
      repeat (3) @(posedge mclk);
      chk("oe_off", module_pin_oe, 0);
      $display("routing done");
      // Output modes on module zero: 8-bit duty, then square wave
      n = 8 + $urandom % 240;
      apb(1'b1, `CAC_ADDR_MOD0, 32'h42);
      apb(1'b1, `CAC_ADDR_MOD0 + `CAC_OFF_VLOW, n);
      apb(1'b1, `CAC_ADDR_MOD0 + `CAC_OFF_VHIGH, n);
      repeat (260) @(posedge mclk);
      m = 0;
      repeat (256)
      begin
         @(posedge mclk);
         m = m + module_pin_out[0];
      end
      chk("pwm8", m >= 255 - n && m <= 257 - n, 1);
      apb(1'b1, `CAC_ADDR_MOD0, 32'h46);
      apb(1'b1, `CAC_ADDR_MOD0 + `CAC_OFF_VLOW, 32'h0);
      apb(1'b1, `CAC_ADDR_MOD0 + `CAC_OFF_VHIGH, 32'h4);
      repeat (260) @(posedge mclk);
      v0 = module_pin_out;
      m = 0;
      repeat (64)
      begin
         @(posedge mclk);
         m = m + (module_pin_out[0] != v0[0]);
         v0 = module_pin_out;
      end
      chk("freq", m >= 15 && m <= 17, 1);
      $display("output modes done");
      conclude;
   end
endmodule // tb_top

bind cac_core cac_core_asserts #(.NMOD(NMOD)) u_cac_core_asserts (.mclk(mclk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .timer0_ovf(timer0_ovf), .ext_osc_clk(ext_osc_clk),
   .external_count_input(external_count_input), .cpu_idle(cpu_idle), .route_enable(route_enable),
   .module_pin_in(module_pin_in), .module_pin_out(module_pin_out), .module_pin_oe(module_pin_oe), .irq(irq));
